/* File: hw/irqls_pkg.sv */
// Purpose: Shared constants for the request latch and share select block
// Assumes: 32-bit Avalon-MM data, one register per aligned word
// Notes:   Register indices are word indices; byte address is four times
package irqls_pkg;

  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [11:0] IRQLS_IDX_PERIPH = 12'hfc0; // Peripheral pending
  localparam logic [11:0] IRQLS_IDX_PIN = 12'hfc3;    // Port pin pending
  localparam logic [11:0] IRQLS_IDX_CTRL = 12'hfcb;   // Global enable
  localparam logic [11:0] IRQLS_IDX_SEL = 12'hfce;    // Shared select

  // ==========================================================
  // Bus geometry
  localparam int IRQLS_ADDR_W = 14;                   // Byte address width
  localparam int IRQLS_DATA_W = 32;                   // Bus data width

  // ==========================================================
  // Field positions
  localparam int IRQLS_PIN7_LOWVOLT_BIT = 7;          // Shared line seven
  localparam int IRQLS_PIN6_COMPARE_BIT = 6;          // Shared line six
  localparam int IRQLS_SERIAL_RX_BIT = 4;             // Serial receiver
  localparam int IRQLS_SERIAL_TX_BIT = 3;             // Serial transmitter
  localparam int IRQLS_CONVERTER_BIT = 0;             // Converter
  localparam int IRQLS_GLOBAL_EN_BIT = 0;             // Vectored mode enable

  // ==========================================================
  // Writable masks; other bits read as zero
  localparam logic [7:0] IRQLS_PIN_MASK = 8'hff;
  localparam logic [7:0] IRQLS_PERIPH_MASK = 8'h19;
  localparam logic [7:0] IRQLS_SEL_MASK = 8'hc0;
  localparam logic [7:0] IRQLS_CTRL_MASK = 8'h01;

  // ==========================================================
  // Reset values
  localparam logic [7:0] IRQLS_PIN_RST = 8'h00;
  localparam logic [7:0] IRQLS_PERIPH_RST = 8'h00;
  localparam logic [7:0] IRQLS_SEL_RST = 8'h00;
  localparam logic [7:0] IRQLS_CTRL_RST = 8'h00;

  // ==========================================================
  // Acknowledge selector: 0..7 pin bits, 8..15 peripheral bits
  localparam logic [3:0] IRQLS_ACK_PERIPH_BASE = 4'h8;

endpackage

/* File: hw/irqls_sync.sv */
// Purpose: Two flip-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to clk_in
// Notes:   First stage is read only by the second stage
module irqls_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================
  // Synchroniser stages
  logic [WIDTH-1:0] meta_r;   // First stage, may be metastable
  logic [WIDTH-1:0] sync_r;   // Second stage, safe to use
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  // Next values: plain shift
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // Registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

/* File: hw/irqls_top.sv */
// Purpose: Latches peripheral and port pin requests, selects shared lines
// Assumes: Avalon-MM slave on clk_in, core acknowledge on the same clock
// Notes:   Pin sources pass a two-stage synchroniser, then edge detect
//          A pin already high at reset release reads as a new edge
//          Writes replace a register, so software may raise a request
//          Byte lane 0 gates writes; reads ignore the byte enables
module irqls_top
  import irqls_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Avalon-MM slave
  input wire logic [IRQLS_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [IRQLS_DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [IRQLS_DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Asynchronous request sources
  input wire logic [PIN_COUNT-1:0] port_pin_in,
  input wire logic low_voltage_detector_in,
  input wire logic compare_in,
  // Same-clock peripheral request pulses
  input wire logic serial_rx_req_in,
  input wire logic serial_tx_req_in,
  input wire logic converter_req_in,
  // Processor core side
  input wire logic core_ack_in,
  input wire logic [3:0] core_ack_sel_in,
  output logic core_irq_out,
  output logic [7:0] pin_request_pending_out,
  output logic [7:0] peripheral_request_pending_out
);

  // ==========================================================
  // Functions

  // Word index from a byte address
  // Only whole words are decoded; the two low bits are ignored
  function automatic logic [11:0] word_index(
    input logic [IRQLS_ADDR_W-1:0] addr
  );
    word_index = addr[IRQLS_ADDR_W-1:2];
  endfunction

  // One-hot clear mask for an acknowledge aimed at one register
  // Selector bit 3 picks the register, bits 2..0 the bit
  function automatic logic [7:0] ack_mask(
    input logic ack,
    input logic [3:0] sel,
    input logic upper
  );
    ack_mask = 8'h00;
    if (ack && (sel[3] == upper)) begin
      ack_mask[sel[2:0]] = 1'b1;
    end
  endfunction

  // ==========================================================
  // Synchronised pin sources
  // All shared sources take the same path, so switching a line
  // never mixes a synchronised level with a raw one
  logic [PIN_COUNT+1:0] src_sync; // Pins, low-voltage, comparator

  irqls_sync #(
    .WIDTH(PIN_COUNT + 2)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({compare_in, low_voltage_detector_in, port_pin_in}),
    .sync_out(src_sync)
  );

  // ==========================================================
  // State declarations
  // Every register here except waitreq_r, which resets high, resets to zero
  logic [7:0] pin_pending_r;        // Port pin request register
  logic [7:0] pin_pending_nxt;
  logic [7:0] periph_pending_r;     // Peripheral request register
  logic [7:0] periph_pending_nxt;
  logic [7:0] share_select_r;       // Shared source select
  logic [7:0] share_select_nxt;
  logic [7:0] ctrl_r;               // Global enable
  logic [7:0] ctrl_nxt;
  logic [7:0] line_prev_r;          // Previous request line levels
  logic [7:0] line_prev_nxt;
  logic waitreq_r;                  // Bus wait request
  logic waitreq_nxt;
  logic [IRQLS_DATA_W-1:0] rdata_r; // Read data
  logic [IRQLS_DATA_W-1:0] rdata_nxt;
  logic irq_r;                      // Request to core
  logic irq_nxt;

  // Combinational helpers
  logic [7:0] req_line;             // Request lines after selection
  logic [7:0] pin_set;              // Rising edges this cycle
  logic [7:0] periph_set;           // Peripheral pulses this cycle
  logic [11:0] idx;                 // Word index of the access
  logic wr_take;                    // Write completes this edge
  logic wr_lane0;                   // Low byte lane enabled

  // ==========================================================
  // Request line selection and edge detection
  always_comb begin
    req_line = '0;
    req_line[5:0] = src_sync[5:0];
    // Pin 7 or the low-voltage detector
    if (share_select_r[IRQLS_PIN7_LOWVOLT_BIT]) begin
      req_line[7] = src_sync[PIN_COUNT];
    end else begin
      req_line[7] = src_sync[7];
    end
    // Pin 6 or the comparator
    if (share_select_r[IRQLS_PIN6_COMPARE_BIT]) begin
      req_line[6] = src_sync[PIN_COUNT+1];
    end else begin
      req_line[6] = src_sync[6];
    end
    line_prev_nxt = req_line;
    // Edge after the mux, so a select change can itself fire
    // Hazard: software must quiet the request before switching;
    // the block itself does not mask the switch
    pin_set = req_line & ~line_prev_r;
  end

  // Previous line levels
  // Reset to zero, the idle level of every source, so no false
  // edge appears after reset while the pins stay low
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_prev_r <= 8'h00;
    end else begin
      line_prev_r <= line_prev_nxt;
    end
  end

  // ==========================================================
  // Bus decode
  // Peripheral pulses come from this clock and need no synchroniser
  always_comb begin
    idx = word_index(avs_address_in);
    wr_take = avs_write_in && !waitreq_r;
    wr_lane0 = avs_byteenable_in[0];
    periph_set = 8'h00;
    periph_set[IRQLS_SERIAL_RX_BIT] = serial_rx_req_in;
    periph_set[IRQLS_SERIAL_TX_BIT] = serial_tx_req_in;
    periph_set[IRQLS_CONVERTER_BIT] = converter_req_in;
  end

  // ==========================================================
  // Pending and configuration registers, next values
  always_comb begin
    pin_pending_nxt = pin_pending_r;
    periph_pending_nxt = periph_pending_r;
    share_select_nxt = share_select_r;
    ctrl_nxt = ctrl_r;
    // Software write: zero clears, one sets a pending bit
    if (wr_take && wr_lane0) begin
      unique case (idx)
        IRQLS_IDX_PIN: begin
          pin_pending_nxt = avs_writedata_in[7:0] & IRQLS_PIN_MASK;
        end
        IRQLS_IDX_PERIPH: begin
          // Reserved bits held at zero whatever is written
          periph_pending_nxt = avs_writedata_in[7:0]
                               & IRQLS_PERIPH_MASK;
        end
        IRQLS_IDX_SEL: begin
          // Low six bits are dropped; software should write zero
          share_select_nxt = avs_writedata_in[7:0]
                             & IRQLS_SEL_MASK;
        end
        IRQLS_IDX_CTRL: begin
          ctrl_nxt = avs_writedata_in[7:0] & IRQLS_CTRL_MASK;
        end
        default: begin
          // Unmapped word: write ignored
        end
      endcase
    end
    // Core acknowledge clears one bit
    // Order matters: write, then acknowledge, then hardware set
    pin_pending_nxt = pin_pending_nxt
                      & ~ack_mask(core_ack_in, core_ack_sel_in,
                                  1'b0);
    periph_pending_nxt = periph_pending_nxt
                         & ~ack_mask(core_ack_in, core_ack_sel_in,
                                     1'b1);
    // New requests applied last so a set beats any clear
    pin_pending_nxt = pin_pending_nxt | pin_set;
    periph_pending_nxt = periph_pending_nxt
                         | periph_set;
  end

  // Pending and configuration registers
  // Reset values come from the package so software sees zeros
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_pending_r <= IRQLS_PIN_RST;
      periph_pending_r <= IRQLS_PERIPH_RST;
      share_select_r <= IRQLS_SEL_RST;
      ctrl_r <= IRQLS_CTRL_RST;
    end else begin
      pin_pending_r <= pin_pending_nxt;
      periph_pending_r <= periph_pending_nxt;
      share_select_r <= share_select_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================
  // Core request: only in vectored mode; polling reads the bits
  // Registered, so the request lags the pending bits by a cycle;
  // the core must tolerate one stale request after an acknowledge
  always_comb begin
    irq_nxt = ctrl_r[IRQLS_GLOBAL_EN_BIT]
              && ((|pin_pending_r) || (|periph_pending_r));
  end

  // Core request register
  // Cleared by reset so no request reaches the core early
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // Avalon handshake: one wait cycle, then a single low cycle
  // Trade-off: read data leave a register, at the cost of two
  // cycles for every transfer, back to back included
  always_comb begin
    waitreq_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if ((avs_read_in || avs_write_in) && waitreq_r) begin
      // Request seen: answer next cycle with data already stable
      waitreq_nxt = 1'b0;
      rdata_nxt = '0;
      if (avs_read_in) begin
        unique case (idx)
          IRQLS_IDX_PIN: begin
            rdata_nxt[7:0] = pin_pending_r;
          end
          IRQLS_IDX_PERIPH: begin
            rdata_nxt[7:0] = periph_pending_r;
          end
          IRQLS_IDX_SEL: begin
            rdata_nxt[7:0] = share_select_r;
          end
          IRQLS_IDX_CTRL: begin
            rdata_nxt[7:0] = ctrl_r;
          end
          default: begin
            // Unmapped word reads zero
            rdata_nxt = '0;
          end
        endcase
      end
    end
  end

  // Bus response registers
  // Wait request idles high so a request is never met early
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      waitreq_r <= 1'b1;
      rdata_r <= '0;
    end else begin
      waitreq_r <= waitreq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  // Pending copies let the core see requests without a bus read
  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = waitreq_r;
  assign core_irq_out = irq_r;
  assign pin_request_pending_out = pin_pending_r;
  assign peripheral_request_pending_out = periph_pending_r;

endmodule

/* File: testbench/irqls_sva.sv */
// Purpose: Port-level checks for the request latch block
// Assumes: One clock domain, reset low and asynchronous
// Notes:   Bound to every irqls_top instance
module irqls_sva #(
  parameter int PIN_COUNT = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Bus handshake
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // Request sources
  input wire logic [PIN_COUNT-1:0] port_pin_in,
  input wire logic serial_rx_req_in,
  input wire logic serial_tx_req_in,
  input wire logic converter_req_in,
  // Core side
  input wire logic core_ack_in,
  input wire logic core_irq_out,
  input wire logic [7:0] pin_request_pending_out,
  input wire logic [7:0] peripheral_request_pending_out
);
  // ==========================================================
  // Short aliases
  wire [7:0] pp = pin_request_pending_out; // Pin pending
  wire [7:0] qp = peripheral_request_pending_out; // Peripheral pending
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // Properties
  a_wait_one_cycle: assert property (
    $fell(avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("waitrequest low for more than a cycle");
  a_irq_needs_pend: assert property (
    !(|{pp, qp, $past(pp), $past(qp)}) |-> !core_irq_out)
    else $error("core request with nothing pending");
  a_rx_sets_bit: assert property (
    serial_rx_req_in |-> ##[1:2] qp[4])
    else $error("receiver request not latched");
  a_tx_sets_bit: assert property (
    serial_tx_req_in |-> ##[1:2] qp[3])
    else $error("transmitter request not latched");
  a_conv_sets_bit: assert property (
    converter_req_in |-> ##[1:2] qp[0])
    else $error("converter request not latched");
  a_reserved_zero: assert property (
    (qp & 8'he6) == 8'h00)
    else $error("reserved peripheral bit set");
  a_pend_holds: assert property (
    |($past(pp) & ~pp) |-> $past(avs_write_in) || $past(core_ack_in))
    else $error("pin pending bit lost without a clear");
  a_pin_edge_sets: assert property (
    $rose(port_pin_in[0]) |-> ##[2:7] pp[0])
    else $error("pin edge not latched");
endmodule

bind irqls_top irqls_sva #(.PIN_COUNT(PIN_COUNT)) u_sva (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .port_pin_in(port_pin_in),
  .serial_rx_req_in(serial_rx_req_in), .serial_tx_req_in(serial_tx_req_in),
  .converter_req_in(converter_req_in), .core_ack_in(core_ack_in),
  .core_irq_out(core_irq_out),
  .pin_request_pending_out(pin_request_pending_out),
  .peripheral_request_pending_out(peripheral_request_pending_out));

/* File: testbench/irqls_core_model.sv */
// Purpose: Processor core stand-in that services forwarded requests
// Assumes: Selector 0..7 names pin bits, 8..15 peripheral bits
// Notes:   serve_in low means polling; WAIT sets how slow it answers
module irqls_core_model #(
  parameter int WAIT = 1 // Service delay in cycles
) (
  // Clock, reset, mode
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic serve_in,
  // Requests from the block
  input wire logic irq_in,
  input wire logic [15:0] pend_in,
  // Acknowledge to the block
  output logic ack_out,
  output logic [3:0] sel_out
);
  // ==========================================================
  // Service
  int cnt; // Cycles waited on a request

  // Lowest pending bit; selector 8+n names peripheral bit n
  function automatic logic [3:0] lowest(input logic [15:0] p);
    lowest = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (p[i]) lowest = 4'(i);
    end
  endfunction

  // Ack only while something is pending: the request line lags a cycle
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      ack_out <= 1'b0;
      sel_out <= 4'h0;
    end else if (cnt >= WAIT && (|pend_in)) begin
      cnt <= 0;
      ack_out <= 1'b1;
      sel_out <= lowest(pend_in);
    end else begin
      ack_out <= 1'b0;
      cnt <= (serve_in && irq_in && !ack_out) ? cnt + 1 : 0;
    end
  end
endmodule

/* File: testbench/irqls_top_tb.sv */
// Purpose: Register-level test of request latching and share select
// Assumes: Bus answers one cycle after a request is taken
// Notes:   Pins are held long enough to pass the synchroniser
module irqls_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import irqls_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic rd_en = 1'b0, wr_en = 1'b0; // Bus direction
  logic [31:0] wdat = 32'h00000000;
  logic [7:0] pins = 8'h00;
  logic lowv = 1'b0, cmp = 1'b0; // Alternate shared sources
  logic rx = 1'b0, tx = 1'b0, conv = 1'b0; // Peripheral requests
  logic serve = 1'b0; // Core services when high
  logic ack, irq, waitr;
  logic [3:0] asel;
  logic [31:0] rdat;
  logic [7:0] pp, qp, v;
  int n_fail = 0, tests_run = 0, cyc = 0;
  always #25 clk_in = ~clk_in;
  // ==========================================================
  // Design and core model
  irqls_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'h1),
    .avs_readdata_out(rdat), .avs_waitrequest_out(waitr),
    .port_pin_in(pins), .low_voltage_detector_in(lowv), .compare_in(cmp),
    .serial_rx_req_in(rx), .serial_tx_req_in(tx), .converter_req_in(conv),
    .core_ack_in(ack), .core_ack_sel_in(asel), .core_irq_out(irq),
    .pin_request_pending_out(pp), .peripheral_request_pending_out(qp));
  irqls_core_model #(.WAIT(1)) core (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .serve_in(serve), .irq_in(irq), .pend_in({qp, pp}), .ack_out(ack),
    .sel_out(asel));
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] got);
    tests_run++;
    if (got !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, e, got);
    end
  endtask
  // One transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] idx,
                     input logic [7:0] d);
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk_in);
    while (waitr !== 1'b0) @(posedge clk_in);
    v = rdat[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input string what, input logic [11:0] idx,
                    input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(what, e, v);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cycle ceiling cuts a hung handshake short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      results();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rd("pin", IRQLS_IDX_PIN, 8'h00);
    rd("select", IRQLS_IDX_SEL, 8'h00);
    bus(1'b1, 12'h001, 8'hff);
    rd("unmapped", 12'h001, 8'h00);
    $display("test reset done");
    // Back-to-back peripheral requests while polling
    rx <= 1'b1;
    @(posedge clk_in);
    rx <= 1'b0;
    tx <= 1'b1;
    @(posedge clk_in);
    tx <= 1'b0;
    conv <= 1'b1;
    @(posedge clk_in);
    conv <= 1'b0;
    rd("periph", IRQLS_IDX_PERIPH, 8'h19);
    chk("periph out", 8'h19, qp);
    chk("irq", 8'h00, {7'h00, irq});
    // Clear while receiver still requests: set wins
    rx <= 1'b1;
    bus(1'b1, IRQLS_IDX_PERIPH, 8'h00);
    rd("periph", IRQLS_IDX_PERIPH, 8'h10);
    rx <= 1'b0;
    bus(1'b1, IRQLS_IDX_PERIPH, 8'h00);
    $display("test peripheral done");
    // Each pin with both shared lines on their pins
    for (int k = 0; k < 8; k++) begin
      pins[k] <= 1'b1;
      repeat (8) @(posedge clk_in);
      chk("pin out", 8'h01 << k, pp);
      rd("pin", IRQLS_IDX_PIN, 8'h01 << k);
      pins[k] <= 1'b0;
      bus(1'b1, IRQLS_IDX_PIN, 8'h00);
    end
    // Alternate sources selected; pins must be ignored
    bus(1'b1, IRQLS_IDX_SEL, 8'hc0);
    rd("select", IRQLS_IDX_SEL, 8'hc0);
    pins[7:6] <= 2'b11;
    repeat (8) @(posedge clk_in);
    rd("pin", IRQLS_IDX_PIN, 8'h00);
    lowv <= 1'b1;
    cmp <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd("pin", IRQLS_IDX_PIN, 8'hc0);
    lowv <= 1'b0;
    cmp <= 1'b0;
    bus(1'b1, IRQLS_IDX_PIN, 8'h00);
    // Switching back to high pins makes an edge itself
    bus(1'b1, IRQLS_IDX_SEL, 8'h00);
    repeat (8) @(posedge clk_in);
    rd("pin", IRQLS_IDX_PIN, 8'hc0);
    pins <= 8'h00;
    bus(1'b1, IRQLS_IDX_PIN, 8'h00);
    $display("test select done");
    // Forwarded request serviced by the core model
    serve <= 1'b1;
    bus(1'b1, IRQLS_IDX_CTRL, 8'h01);
    conv <= 1'b1;
    @(posedge clk_in);
    conv <= 1'b0;
    for (int n = 0; n < 20 && irq !== 1'b1; n++) @(posedge clk_in);
    chk("irq", 8'h01, {7'h00, irq});
    for (int n = 0; n < 20 && irq !== 1'b0; n++) @(posedge clk_in);
    chk("irq", 8'h00, {7'h00, irq});
    rd("periph", IRQLS_IDX_PERIPH, 8'h00);
    // Pin request forwarded and cleared by a core acknowledge
    pins[2] <= 1'b1;
    for (int n = 0; n < 20 && irq !== 1'b1; n++) @(posedge clk_in);
    chk("irq", 8'h01, {7'h00, irq});
    for (int n = 0; n < 20 && irq !== 1'b0; n++) @(posedge clk_in);
    chk("irq", 8'h00, {7'h00, irq});
    rd("pin", IRQLS_IDX_PIN, 8'h00);
    pins[2] <= 1'b0;
    $display("test vectored done");
    results();
  end
endmodule
